// >>> pdm_module_port.sv
// Module end: paged window, page, control mailbox and id register.
`timescale 1ns/1ps
module pdm_module_port (
    input wire logic mclk,
    input wire logic rstn,
    pdm_bus_if.module_end bus,
    input wire logic bootSourceStrap,
    input wire logic locPollSet,
    input wire logic locHostIrqSet,
    input wire logic [14:0] locAddr,
    input wire logic locWe,
    input wire logic [15:0] locWdata,
    output logic [15:0] locRdata,
    output logic localCpuReset,
    output logic localIrqRequest,
    output logic idSelect,
    output logic idClock,
    output logic idDataIn,
    input wire logic idDataOut
);
    logic [9:0] pageSelect;
    logic pollFlag;
    logic localReset;
    logic localIrq;
    logic hostIrq;
    logic [1:0] strapAge;
    logic strapS1;
    logic strapS2;
    logic idDoS1;
    logic idDoS2;
    logic readPending;
    logic readWindow;
    logic [15:0] regData;
    logic [15:0] ramRdata;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire hitWindow = bus.addr <= pdm_pkg::PDM_WINDOW_LAST;
    wire hitPage = bus.addr == pdm_pkg::PDM_OFS_PAGE;
    wire hitCtrl = bus.addr == pdm_pkg::PDM_OFS_CTRL;
    wire hitId = bus.addr == pdm_pkg::PDM_OFS_ID;
    // Page bit 9 lies above the 64 KB store and is only read back.
    wire [14:0] ramAddr = {pageSelect[8:0], bus.addr[6:1]};
    wire ramWe = bus.wr && hitWindow;
    wire pageWr = bus.wr && hitPage;
    wire ctrlWr = bus.wr && hitCtrl;
    wire idWr = bus.wr && hitId;
    wire pollClear = ctrlWr && bus.wdata[pdm_pkg::PDM_BIT_POLL];
    wire hostIrqClear = ctrlWr && bus.wdata[pdm_pkg::PDM_BIT_HOST_IRQ_REQUEST];
    wire strapSample = strapAge == pdm_pkg::PDM_STRAP_SETTLE;
    wire romBoot = strapSample && strapS2 == pdm_pkg::PDM_STRAP_ROM;
    wire pollSet = locPollSet && !localReset;
    wire [15:0] ctrlView = {12'h000, hostIrq, localIrq, localReset, pollFlag};
    wire [15:0] idView = {13'h0000, idDoS2, idClock, idSelect};
    wire [15:0] next_regData = hitPage ? {6'h00, pageSelect} :
                               hitCtrl ? ctrlView :
                               hitId ? idView : 16'h0000;

    // ------------------------------------------------------------
    // Shared memory
    // ------------------------------------------------------------
    pdm_shared_ram ram (
        .mclk(mclk),
        .hostAddr(ramAddr),
        .hostWe(ramWe),
        .hostWdata(bus.wdata),
        .hostRdata(ramRdata),
        .locAddr(locAddr),
        .locWe(locWe),
        .locWdata(locWdata),
        .locRdata(locRdata)
    );

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapS1 <= 1'b0;
            strapS2 <= 1'b0;
            idDoS1 <= 1'b0;
            idDoS2 <= 1'b0;
        end else begin
            strapS1 <= bootSourceStrap;
            strapS2 <= strapS1;
            idDoS1 <= idDataOut;
            idDoS2 <= idDoS1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pageSelect <= pdm_pkg::PDM_PAGE_RST;
        end else if (pageWr) begin
            pageSelect <= bus.wdata[pdm_pkg::PDM_PAGE_W-1:0];
        end
    end

    // The id pins are plain register bits that the host toggles.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            idSelect <= 1'b0;
            idClock <= 1'b0;
            idDataIn <= 1'b0;
        end else if (idWr) begin
            idSelect <= bus.wdata[pdm_pkg::PDM_BIT_CS];
            idClock <= bus.wdata[pdm_pkg::PDM_BIT_SCK];
            idDataIn <= bus.wdata[pdm_pkg::PDM_BIT_DIO];
        end
    end

    // ------------------------------------------------------------
    // Boot strap sequencing
    // ------------------------------------------------------------
    // The strap is read once, when its synchroniser has filled.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapAge <= 2'h0;
        end else if (strapAge != pdm_pkg::PDM_STRAP_DONE) begin
            strapAge <= strapAge + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Local reset
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            localReset <= pdm_pkg::PDM_LRESET_RST;
        end else if (romBoot) begin
            localReset <= 1'b0;
        end else if (ctrlWr) begin
            localReset <= bus.wdata[pdm_pkg::PDM_BIT_RESET];
        end
    end

    // ------------------------------------------------------------
    // Poll flag
    // ------------------------------------------------------------
    // Out of local reset, a set from the local side wins over a clear in the same cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pollFlag <= 1'b0;
        end else if (pollSet) begin
            pollFlag <= 1'b1;
        end else if (pollClear) begin
            pollFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Local interrupt
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            localIrq <= 1'b0;
        end else if (localReset) begin
            localIrq <= 1'b0;
        end else if (ctrlWr) begin
            localIrq <= bus.wdata[pdm_pkg::PDM_BIT_LOCAL_IRQ_REQUEST];
        end
    end

    // ------------------------------------------------------------
    // Host interrupt
    // ------------------------------------------------------------
    // A set from the local side wins over a host clear in the same cycle; local reset wins over both.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostIrq <= 1'b0;
        end else if (localReset) begin
            hostIrq <= 1'b0;
        end else if (locHostIrqSet) begin
            hostIrq <= 1'b1;
        end else if (hostIrqClear) begin
            hostIrq <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            readPending <= 1'b0;
            readWindow <= 1'b0;
            regData <= 16'h0000;
        end else begin
            readPending <= bus.rd;
            readWindow <= hitWindow;
            regData <= next_regData;
        end
    end

    assign bus.rdata = readWindow ? ramRdata : regData;
    assign bus.ack = bus.wr || readPending;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.hostIrq = hostIrq;
    assign localCpuReset = localReset;
    assign localIrqRequest = localIrq && !localReset;
endmodule : pdm_module_port

// >>> pdm_pkg.sv
// Package of constants and types shared by the mailbox host port design.
// Operation
// - Window at 0, page 0x80, control 0x82, id 0xfe.
// - Shared memory is 512 pages of 128 bytes.
// - Offsets 0x00 to 0x7e hit selected page.
// - Host writes shared memory only as words.
// - Page gives A16-A7, offset gives A6-A0.
// - Poll reads state, host one clears, local sets.
// - Local reset holds processor, clears interrupt requests.
// - Local reset set at power-up, cleared on ROM boot.
// - Local request bit interrupts the local processor.
// - Host request reads line, write one clears it.
// - Id register drives select, clock, data; reads data.
// - Id store is 64 words, bit-banged serial.
// - Host interrupt is level, cleared by host software.
// - ROM boot runs alone, sets poll when ready.
// - RAM boot loads image from page 0, offset 0.
// - Host clears reset, then waits for poll.
// - Running host writes shared memory only in page 4.
// - Polled command: clear poll, parameters, command last.
package pdm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PDM_OFS_PAGE = 8'h80;
    localparam logic [7:0] PDM_OFS_CTRL = 8'h82;
    localparam logic [7:0] PDM_OFS_ID = 8'hfe;
    localparam logic [7:0] PDM_WINDOW_LAST = 8'h7e;

    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int PDM_PAGES = 512;
    localparam int PDM_PAGE_BYTES = 128;
    localparam int PDM_WORDS = PDM_PAGES * PDM_PAGE_BYTES / 2;
    localparam int PDM_PAGE_W = 10;
    localparam int PDM_ID_WORDS = 64;
    localparam logic [9:0] PDM_CMD_PAGE = 10'h004;

    // ------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------
    localparam int PDM_BIT_POLL = 0;
    localparam int PDM_BIT_RESET = 1;
    localparam int PDM_BIT_LOCAL_IRQ_REQUEST = 2;
    localparam int PDM_BIT_HOST_IRQ_REQUEST = 3;
    localparam int PDM_BIT_CS = 0;
    localparam int PDM_BIT_SCK = 1;
    localparam int PDM_BIT_DIO = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0] PDM_PAGE_RST = 10'h000;
    localparam logic PDM_LRESET_RST = 1'b1;
    localparam logic PDM_STRAP_ROM = 1'b1;
    localparam logic [1:0] PDM_STRAP_SETTLE = 2'h2;
    localparam logic [1:0] PDM_STRAP_DONE = 2'h3;

    typedef enum logic [1:0] {
        PDM_H_IDLE = 2'b00,
        PDM_H_WAIT = 2'b01,
        PDM_H_DONE = 2'b10
    } pdm_hstate_type;

endpackage : pdm_pkg

// >>> pdm_bus_if.sv
// Interface joining the host and the module port.
`timescale 1ns/1ps
interface pdm_bus_if;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic ack;
    logic hostIrq;

    modport module_end (
        input addr, wdata, wr, rd,
        output rdata, ack, hostIrq
    );
    modport host_end (
        output addr, wdata, wr, rd,
        input rdata, ack, hostIrq
    );
endinterface : pdm_bus_if

// >>> pdm_shared_ram.sv
// Word-wide shared memory with a host port and a local port.
`timescale 1ns/1ps
module pdm_shared_ram (
    input wire logic mclk,
    input wire logic [14:0] hostAddr,
    input wire logic hostWe,
    input wire logic [15:0] hostWdata,
    output logic [15:0] hostRdata,
    input wire logic [14:0] locAddr,
    input wire logic locWe,
    input wire logic [15:0] locWdata,
    output logic [15:0] locRdata
);
    logic [15:0] mem [0:pdm_pkg::PDM_WORDS-1];

    // Both ports read and write synchronously; the local port wins a tie.
    always_ff @(posedge mclk) begin
        if (hostWe && !(locWe && locAddr == hostAddr)) begin
            mem[hostAddr] <= hostWdata;
        end
        if (locWe) begin
            mem[locAddr] <= locWdata;
        end
        hostRdata <= mem[hostAddr];
        locRdata <= mem[locAddr];
    end
endmodule : pdm_shared_ram

// >>> pdm_host_end.sv
// Host end: turns user requests into single-cycle module accesses.
`timescale 1ns/1ps
module pdm_host_end (
    input wire logic mclk,
    input wire logic rstn,
    pdm_bus_if.host_end bus,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [7:0] reqAddr,
    input wire logic [15:0] reqWdata,
    output logic reqReady,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic irqPending
);
    pdm_pkg::pdm_hstate_type state;
    pdm_pkg::pdm_hstate_type next_state;
    logic [7:0] addrReg;
    logic [15:0] wdataReg;
    logic writeReg;

    wire start = reqValid && state == pdm_pkg::PDM_H_IDLE;

    // Word writes only; user traffic follows the boot and page discipline.
    always_comb begin
        case (state)
            pdm_pkg::PDM_H_IDLE: next_state = start ?
                pdm_pkg::PDM_H_WAIT : pdm_pkg::PDM_H_IDLE;
            pdm_pkg::PDM_H_WAIT: next_state = bus.ack ?
                pdm_pkg::PDM_H_DONE : pdm_pkg::PDM_H_WAIT;
            pdm_pkg::PDM_H_DONE: next_state = pdm_pkg::PDM_H_IDLE;
            default: next_state = pdm_pkg::PDM_H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= pdm_pkg::PDM_H_IDLE;
            addrReg <= 8'h00;
            wdataReg <= 16'h0000;
            writeReg <= 1'b0;
            rspData <= 16'h0000;
            irqPending <= 1'b0;
        end else begin
            state <= next_state;
            irqPending <= bus.hostIrq;
            if (start) begin
                addrReg <= {reqAddr[7:1], 1'b0};
                wdataReg <= reqWdata;
                writeReg <= reqWrite;
            end
            if (state == pdm_pkg::PDM_H_WAIT && bus.ack) begin
                rspData <= bus.rdata;
            end
        end
    end

    wire inWait = state == pdm_pkg::PDM_H_WAIT;
    wire firstCycle = inWait && !bus.ack;
    assign bus.addr = addrReg;
    assign bus.wdata = wdataReg;
    assign bus.wr = inWait && writeReg;
    assign bus.rd = firstCycle && !writeReg && state != pdm_pkg::PDM_H_DONE;
    assign reqReady = state == pdm_pkg::PDM_H_IDLE;
    assign rspValid = state == pdm_pkg::PDM_H_DONE;
endmodule : pdm_host_end

// >>> pdm_bus_properties.sv
// Checker of the bus that joins the host end and the module end.
`timescale 1ns/1ps
module pdm_bus_properties (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic ack,
    input wire logic hostIrq
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [9:0] lastPage;
    logic ctrlWr;
    logic unmapped;
    assign ctrlWr = wr && addr == pdm_pkg::PDM_OFS_CTRL;
    assign unmapped = addr[7] && !addr[0] && addr != pdm_pkg::PDM_OFS_PAGE
        && addr != pdm_pkg::PDM_OFS_CTRL && addr != pdm_pkg::PDM_OFS_ID;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lastPage <= 10'h000;
        end else if (wr && addr == pdm_pkg::PDM_OFS_PAGE) begin
            lastPage <= wdata[9:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    write_ack_a: assert property (wr |-> ack ##1 !wr)
        else $error("write not acknowledged in its cycle");
    read_ack_a: assert property (rd |=> ack && !rd)
        else $error("read not acknowledged one cycle later");
    ack_cause_a: assert property (ack |-> wr || $past(rd))
        else $error("acknowledge without a request");
    one_access_a: assert property (!(wr && rd))
        else $error("read and write together");
    unmapped_zero_a: assert property (rd && unmapped
        |=> rdata == 16'h0000)
        else $error("unmapped offset read not zero");
    page_read_a: assert property (rd && addr == pdm_pkg::PDM_OFS_PAGE
        |=> rdata[9:0] == lastPage)
        else $error("page select read back wrong");
    ctrl_irq_a: assert property (rd && addr == pdm_pkg::PDM_OFS_CTRL
        |=> rdata[3] == $past(hostIrq))
        else $error("host request bit differs from line");
    irq_hold_a: assert property (hostIrq && !ctrlWr && !$past(ctrlWr)
        |=> hostIrq)
        else $error("host interrupt dropped without clear");
    cover property (wr && addr == pdm_pkg::PDM_OFS_PAGE);
    cover property (rd && unmapped);
    cover property (hostIrq && ctrlWr);
endmodule : pdm_bus_properties

// >>> testbench.sv
// Self-checking testbench of the two joined ends.
`timescale 1ns/1ps
module testbench;
    logic mclk, rstn, bootSourceStrap, locPollSet, locHostIrqSet, locWe;
    logic reqValid, reqWrite, reqReady, rspValid, irqPending, idDataOut;
    logic localCpuReset, localIrqRequest, idSelect, idClock, idDataIn;
    logic [7:0] reqAddr;
    logic [14:0] locAddr;
    logic [15:0] reqWdata, rspData, locWdata, locRdata;
    int fail_count, tests_run;
    pdm_bus_if bus();
    pdm_module_port i_pdm_module_port(.mclk, .rstn, .bus(bus),
        .bootSourceStrap, .locPollSet, .locHostIrqSet, .locAddr, .locWe,
        .locWdata, .locRdata, .localCpuReset, .localIrqRequest, .idSelect,
        .idClock, .idDataIn, .idDataOut);
    pdm_host_end i_pdm_host_end(.mclk, .rstn, .bus(bus), .reqValid,
        .reqWrite, .reqAddr, .reqWdata, .reqReady, .rspValid, .rspData,
        .irqPending);
    pdm_bus_properties i_pdm_bus_properties(.mclk, .rstn,
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .wr(bus.wr),
        .rd(bus.rd), .ack(bus.ack), .hostIrq(bus.hostIrq));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        reqWrite = w;
        reqAddr = a;
        reqWdata = d;
        reqValid = 1'b1;
        while (reqReady !== 1'b1) @(posedge mclk) #1;
        @(posedge mclk) #1;
        reqValid = 1'b0;
        repeat (8) if (rspValid !== 1'b1) @(posedge mclk) #1;
        chk("rspValid", 16'h0001, {15'h0000, rspValid});
        @(posedge mclk) #1;
    endtask : acc
    task automatic rdchk(input string n, input logic [7:0] a,
        input logic [15:0] m, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(n, e, rspData & m);
    endtask : rdchk
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge mclk) #1;
        s = 1'b0;
        repeat (3) @(posedge mclk) #1;
    endtask : pulse
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_boot;
        acc(1'b1, 8'h80, 16'h0000);
        acc(1'b1, 8'h00, 16'h5a3c);
        acc(1'b1, 8'h02, 16'hc3a5);
        locAddr = 15'h0001;
        repeat (2) @(posedge mclk) #1;
        chk("bootWord", 16'hc3a5, locRdata);
        locAddr = 15'h0000;
        repeat (2) @(posedge mclk) #1;
        chk("bootStart", 16'h5a3c, locRdata);
    endtask : s_boot
    task automatic s_window;
        acc(1'b1, 8'h80, 16'h01ff);
        acc(1'b1, 8'h7e, 16'hbeef);
        rdchk("page", 8'h80, 16'h03ff, 16'h01ff);
        locAddr = 15'h7fff;
        repeat (2) @(posedge mclk) #1;
        chk("localWord", 16'hbeef, locRdata);
        locAddr = 15'h7fc0;
        locWdata = 16'h1234;
        locWe = 1'b1;
        @(posedge mclk) #1;
        locWe = 1'b0;
        rdchk("window", 8'h00, 16'hffff, 16'h1234);
    endtask : s_window
    task automatic s_ctrl;
        chk("heldReset", 16'h0001, {15'h0000, localCpuReset});
        pulse(locPollSet);
        rdchk("pollHeld", 8'h82, 16'h000f, 16'h0002);
        acc(1'b1, 8'h82, 16'h0000);
        chk("released", 16'h0000, {15'h0000, localCpuReset});
        pulse(locPollSet);
        acc(1'b1, 8'h82, 16'h0000);
        rdchk("pollKept", 8'h82, 16'h000f, 16'h0001);
        acc(1'b1, 8'h82, 16'h0001);
        rdchk("pollClear", 8'h82, 16'h000f, 16'h0000);
        acc(1'b1, 8'h80, 16'h0004);
        acc(1'b1, 8'h02, 16'h0011);
        acc(1'b1, 8'h00, 16'h0022);
        locAddr = 15'h0100;
        repeat (2) @(posedge mclk) #1;
        chk("command", 16'h0022, locRdata);
        acc(1'b1, 8'h82, 16'h0004);
        chk("localIrq", 16'h0001, {15'h0000, localIrqRequest});
        pulse(locHostIrqSet);
        chk("irqPending", 16'h0001, {15'h0000, irqPending});
        rdchk("hostIrq", 8'h82, 16'h000f, 16'h000c);
        acc(1'b1, 8'h82, 16'h000c);
        rdchk("hostClr", 8'h82, 16'h000f, 16'h0004);
        chk("irqDropped", 16'h0000, {15'h0000, irqPending});
        pulse(locHostIrqSet);
        acc(1'b1, 8'h82, 16'h0006);
        chk("irqCleared", 16'h0000, {15'h0000, localIrqRequest});
        rdchk("resetCtrl", 8'h82, 16'h000f, 16'h0002);
    endtask : s_ctrl
    task automatic s_id;
        logic [15:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 16'h0007 : 16'h0002;
            idDataOut = v[0];
            acc(1'b1, 8'hfe, v);
            chk("idPins", v,
                {13'h0000, idDataIn, idClock, idSelect});
            rdchk("idData", 8'hfe, 16'h0004, {13'h0000, v[0], 2'b00});
        end
        acc(1'b1, 8'h90, 16'hffff);
        rdchk("unmapped", 8'h90, 16'hffff, 16'h0000);
        rdchk("pageKept", 8'h80, 16'h03ff, 16'h0004);
    endtask : s_id
    task automatic s_rom;
        rstn = 1'b0;
        bootSourceStrap = 1'b1;
        repeat (3) @(posedge mclk) #1;
        rstn = 1'b1;
        @(posedge mclk) #1;
        chk("romHeld", 16'h0001, {15'h0000, localCpuReset});
        repeat (5) @(posedge mclk) #1;
        chk("romRun", 16'h0000, {15'h0000, localCpuReset});
        rdchk("pageReset", 8'h80, 16'h03ff, 16'h0000);
        pulse(locPollSet);
        rdchk("romReady", 8'h82, 16'h000f, 16'h0001);
    endtask : s_rom
    initial begin
        {rstn, bootSourceStrap, locPollSet, locHostIrqSet, locWe} = 5'h00;
        {reqValid, reqWrite, idDataOut} = 3'h0;
        reqAddr = 8'h00;
        reqWdata = 16'h0000;
        locAddr = 15'h0000;
        locWdata = 16'h0000;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        @(posedge mclk) #1;
        s_boot();
        s_window();
        s_ctrl();
        s_id();
        s_rom();
        end_sim();
    end
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule : testbench
